// ### logic/eeprom_i2c_pkg.sv
package eeprom_i2c_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int LINK_CLK_PERIOD_NS = 32;
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam int T_PROG_MS = 10;
    localparam int T_NOISE_NS = 50;
    localparam int T_SCL_LOW_NS = 1300;
    // longest time: round down
    localparam int PROG_CYCLES_DEF = (T_PROG_MS * 1000000) / LINK_CLK_PERIOD_NS;
    // least times: round up
    localparam int FILT_CYCLES = (T_NOISE_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;
    localparam int SCL_QTR_CYCLES = (T_SCL_LOW_NS / 2 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // select byte
    // ------------------------------------------------------------
    localparam logic [3:0] MEM_TYPE_ID = 4'ha;
    localparam logic [3:0] PROT_TYPE_ID = 4'h6;
    localparam int PAGE_BITS = 4;
    localparam logic [7:0] PROT_RESET = 8'h00;

    // ------------------------------------------------------------
    // host control registers
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ACK_BIT = 3;
    localparam int CMD_DATA_LSB = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    localparam int STAT_DATA_LSB = 8;
    localparam logic [2:0] OP_START = 3'h1;
    localparam logic [2:0] OP_STOP = 3'h2;
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [2:0] OP_READ = 3'h4;

    typedef enum logic [3:0] {S_IDLE, S_SEL, S_ACK_SEL, S_RX, S_ACK_RX, S_TX, S_TX_ACK,
        S_WAIT_STOP, S_PROG} dev_state_t;
    typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BIT} host_state_t;

endpackage

// ### logic/eeprom_i2c_if.sv
`timescale 1ns/100ps
interface eeprom_i2c_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic sda;

    // open drain with pull-up: any enabled driver pulling low wins
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

    modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

// ### logic/eeprom_i2c_dev.sv
// Functional notes
// RQ1: start is data falling while clock high
// RQ2: ignore bus until start seen
// RQ3: stop is data rising while clock high
// RQ4: stop returns device to standby
// RQ5: transmitter releases; receiver acks ninth clock
// RQ6: ack select byte matching type and straps
// RQ7: ack every byte of a write
// RQ8: read: send byte, sample ack, continue
// RQ9: no ack: stop sending, await stop
// RQ10: select: type, three straps, direction, msb first
// RQ11: type a selects memory, 6 protection
// RQ12: direction one reads at current pointer
// RQ13: random read: address write then restart
// RQ14: sequential read while master keeps acking
// RQ15: writes need control low; page sixteen
// RQ16: program cycle after write; no ack
// RQ17: filter lines before start or stop
// RQ18: data changes only while clock low
`timescale 1ns/100ps
module eeprom_i2c_dev
    import eeprom_i2c_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DEF,
    parameter int FILT = FILT_CYCLES
)
(
    // link side
    input wire logic link_clk,
    input wire logic link_srst,
    eeprom_i2c_if.dev bus,
    // straps and write control
    input wire logic addr_strap_bit2,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit0,
    input wire logic write_control_pin,
    // status
    output logic standby,
    output logic prog_busy
);

    localparam int PW = $clog2(PROG_CYCLES + 1);

    if (PROG_CYCLES < 1 || FILT < 1 || FILT > 15)
    begin : g_bad_param
        $error("eeprom_i2c_dev: bad parameter");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] pin_m_q;
    logic [5:0] pin_s_q;

    always_ff @(posedge link_clk)
    begin
        pin_m_q <= {bus.scl, bus.sda, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, write_control_pin};
        pin_s_q <= pin_m_q;
    end

    wire logic [2:0] strap_s = pin_s_q[3:1];
    wire logic wc_s = pin_s_q[0];

    // ------------------------------------------------------------
    // glitch filter on clock and data
    // ------------------------------------------------------------
    logic [1:0] flt_q;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_flt
            logic [3:0] flt_cnt_q;
            // RQ17 settle delay
            always_ff @(posedge link_clk)
            begin
                if (link_srst)
                begin
                    flt_cnt_q <= 4'h0;
                    flt_q[gi] <= 1'b1;
                end
                else if (pin_s_q[4 + gi] == flt_q[gi])
                    flt_cnt_q <= 4'h0;
                else if (flt_cnt_q == 4'(FILT - 1))
                begin
                    flt_cnt_q <= 4'h0;
                    flt_q[gi] <= pin_s_q[4 + gi];
                end
                else
                    flt_cnt_q <= flt_cnt_q + 4'h1;
            end
        end
    endgenerate

    wire logic scl_f = flt_q[1];
    wire logic sda_f = flt_q[0];
    logic scl_p_q;
    logic sda_p_q;

    always_ff @(posedge link_clk)
    begin
        if (link_srst)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    wire logic rise = scl_f & ~scl_p_q;
    wire logic fall = ~scl_f & scl_p_q;
    // RQ1 start detect
    wire logic start = scl_f & scl_p_q & sda_p_q & ~sda_f;
    // RQ3 stop detect
    wire logic stop = scl_f & scl_p_q & ~sda_p_q & sda_f;

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    dev_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic prot_q;
    logic first_q;
    logic wrote_q;
    logic ack_seen_q;
    logic oe_n_q;
    logic [7:0] prot_reg_q;
    logic [7:0] mem [0:255];
    logic [PW-1:0] prog_cnt_q;

    wire logic prog_done = prog_cnt_q == PW'(PROG_CYCLES - 1);
    wire logic [7:0] rd_byte = prot_q ? prot_reg_q : mem[ptr_q];
    // RQ10 select layout
    wire logic type_hit = sh_q[7:4] == MEM_TYPE_ID || sh_q[7:4] == PROT_TYPE_ID;
    wire logic sel_hit = type_hit && sh_q[3:1] == strap_s;
    wire logic byte_in = state_q == S_RX && fall && cnt_q == 4'd8;
    // RQ15 write control gating
    wire logic data_we = byte_in && !first_q && !wc_s;

    always_ff @(posedge link_clk)
    begin
        if (link_srst)
        begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            prot_q <= 1'b0;
            first_q <= 1'b0;
            wrote_q <= 1'b0;
            ack_seen_q <= 1'b0;
            oe_n_q <= 1'b1;
        end
        // RQ16 bus disabled while programming
        else if (state_q == S_PROG)
        begin
            oe_n_q <= 1'b1;
            if (prog_done)
                state_q <= S_IDLE;
        end
        else if (stop)
        begin
            // RQ4 standby or program
            oe_n_q <= 1'b1;
            wrote_q <= 1'b0;
            state_q <= wrote_q ? S_PROG : S_IDLE;
        end
        else if (start)
        begin
            // RQ2 only a start wakes us
            oe_n_q <= 1'b1;
            cnt_q <= 4'h0;
            state_q <= S_SEL;
        end
        else
        begin
            case (state_q)
                S_IDLE, S_WAIT_STOP:
                    oe_n_q <= 1'b1;
                S_SEL:
                    if (rise)
                    begin
                        sh_q <= {sh_q[6:0], sda_f};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    else if (fall && cnt_q == 4'd8)
                    begin
                        // RQ6 ack matching select
                        if (sel_hit)
                        begin
                            oe_n_q <= 1'b0;
                            rw_q <= sh_q[0];
                            // RQ11 target choice
                            prot_q <= sh_q[7:4] == PROT_TYPE_ID;
                            state_q <= S_ACK_SEL;
                        end
                        else
                            state_q <= S_WAIT_STOP;
                    end
                S_ACK_SEL:
                    if (fall)
                    begin
                        cnt_q <= 4'h0;
                        first_q <= ~rw_q;
                        // RQ12 read at pointer
                        if (rw_q)
                        begin
                            sh_q <= rd_byte;
                            oe_n_q <= rd_byte[7];
                            ptr_q <= ptr_q + 8'h01;
                            state_q <= S_TX;
                        end
                        else
                        begin
                            oe_n_q <= 1'b1;
                            state_q <= S_RX;
                        end
                    end
                S_RX:
                    if (rise)
                    begin
                        sh_q <= {sh_q[6:0], sda_f};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    else if (byte_in)
                    begin
                        // RQ7 ack each written byte
                        oe_n_q <= 1'b0;
                        state_q <= S_ACK_RX;
                        // RQ13 first byte loads pointer
                        if (first_q)
                        begin
                            ptr_q <= sh_q;
                            first_q <= 1'b0;
                        end
                        else if (data_we)
                        begin
                            // RQ15 roll within the page
                            wrote_q <= 1'b1;
                            ptr_q <= {ptr_q[7:PAGE_BITS], ptr_q[PAGE_BITS-1:0] + PAGE_BITS'(1)};
                        end
                    end
                S_ACK_RX:
                    if (fall)
                    begin
                        // RQ5 release after ninth clock
                        oe_n_q <= 1'b1;
                        cnt_q <= 4'h0;
                        state_q <= S_RX;
                    end
                S_TX:
                    if (rise)
                        cnt_q <= cnt_q + 4'h1;
                    else if (fall)
                    begin
                        // RQ18 change data on falling clock
                        if (cnt_q == 4'd8)
                        begin
                            // RQ5 release for the ack
                            oe_n_q <= 1'b1;
                            ack_seen_q <= 1'b0;
                            state_q <= S_TX_ACK;
                        end
                        else
                            oe_n_q <= sh_q[3'(4'd7 - cnt_q)];
                    end
                S_TX_ACK:
                    if (rise)
                    begin
                        // RQ9 no ack ends sending
                        if (sda_f)
                            state_q <= S_WAIT_STOP;
                        else
                            ack_seen_q <= 1'b1;
                    end
                    else if (fall && ack_seen_q)
                    begin
                        // RQ8 RQ14 next sequential byte
                        sh_q <= rd_byte;
                        oe_n_q <= rd_byte[7];
                        ptr_q <= ptr_q + 8'h01;
                        cnt_q <= 4'h0;
                        state_q <= S_TX;
                    end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // storage and program timer
    // ------------------------------------------------------------
    // array writes land at once; the program cycle only models the busy time
    always_ff @(posedge link_clk)
    begin
        if (data_we && !prot_q)
            mem[ptr_q] <= sh_q;
    end

    always_ff @(posedge link_clk)
    begin
        if (link_srst)
            prot_reg_q <= PROT_RESET;
        else if (data_we && prot_q)
            prot_reg_q <= sh_q;
    end

    // RQ16 program time count
    always_ff @(posedge link_clk)
    begin
        if (link_srst || state_q != S_PROG)
            prog_cnt_q <= '0;
        else
            prog_cnt_q <= prog_cnt_q + PW'(1);
    end

    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe_n = oe_n_q;
    assign standby = state_q == S_IDLE;
    assign prog_busy = state_q == S_PROG;

endmodule

// ### logic/eeprom_i2c_host.sv
`timescale 1ns/100ps
module eeprom_i2c_host
    import eeprom_i2c_pkg::*;
#(
    parameter int QTR = SCL_QTR_CYCLES
)
(
    // system
    input wire logic sys_clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // link
    eeprom_i2c_if.host bus
);

    if (QTR < 4 || QTR > 255)
    begin : g_bad_qtr
        $error("eeprom_i2c_host: bad QTR");
    end

    // ------------------------------------------------------------
    // data line synchroniser
    // ------------------------------------------------------------
    logic sda_m_q;
    logic sda_s_q;

    always_ff @(posedge sys_clk)
    begin
        sda_m_q <= bus.sda;
        sda_s_q <= sda_m_q;
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    host_state_t state_q;
    logic [7:0] q_q;
    logic [1:0] ph_q;
    logic [3:0] bidx_q;
    logic [8:0] tx_q;
    logic [8:0] rx_q;
    logic [7:0] rx_byte_q;
    logic nack_q;
    logic scl_q;
    logic oe_n_q;

    wire logic [2:0] op = reg_wdata[CMD_OP_LSB +: 3];
    wire logic [7:0] wbyte = reg_wdata[CMD_DATA_LSB +: 8];
    // a command written while busy is dropped
    wire logic take = reg_wr && reg_addr == REG_CMD && state_q == H_IDLE;
    wire logic tick = q_q == 8'(QTR - 1);
    // RQ5 RQ10 msb first, ninth bit ack
    wire logic [8:0] tx_new = op == OP_READ ? {8'hff, reg_wdata[CMD_ACK_BIT]} : {wbyte, 1'b1};

    always_ff @(posedge sys_clk)
    begin
        if (srst || state_q == H_IDLE || tick)
            q_q <= 8'h00;
        else
            q_q <= q_q + 8'h01;
    end

    // ------------------------------------------------------------
    // bit engine: four quarters per bit, clock high in the middle two
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_q <= H_IDLE;
            ph_q <= 2'h0;
            bidx_q <= 4'h0;
            tx_q <= 9'h1ff;
            rx_q <= 9'h000;
            rx_byte_q <= 8'h00;
            nack_q <= 1'b0;
            scl_q <= 1'b1;
            oe_n_q <= 1'b1;
        end
        else if (take)
        begin
            ph_q <= 2'h0;
            bidx_q <= 4'h0;
            case (op)
                OP_START:
                begin
                    oe_n_q <= 1'b1;
                    state_q <= H_START;
                end
                OP_STOP:
                begin
                    oe_n_q <= 1'b0;
                    state_q <= H_STOP;
                end
                OP_WRITE, OP_READ:
                begin
                    oe_n_q <= tx_new[8];
                    tx_q <= {tx_new[7:0], 1'b1};
                    state_q <= H_BIT;
                end
                default:
                    state_q <= H_IDLE;
            endcase
        end
        else if (tick)
        begin
            ph_q <= ph_q + 2'h1;
            case (state_q)
                // RQ1 data falls, clock high
                H_START:
                    case (ph_q)
                        2'h0: scl_q <= 1'b1;
                        2'h1: oe_n_q <= 1'b0;
                        2'h2: scl_q <= 1'b0;
                        default: state_q <= H_IDLE;
                    endcase
                // RQ3 data rises, clock high
                H_STOP:
                    case (ph_q)
                        2'h0: scl_q <= 1'b1;
                        2'h1: oe_n_q <= 1'b1;
                        2'h2: scl_q <= 1'b1;
                        default: state_q <= H_IDLE;
                    endcase
                // RQ18 data moves with clock low
                H_BIT:
                    case (ph_q)
                        2'h0: scl_q <= 1'b1;
                        2'h1: scl_q <= 1'b1;
                        2'h2:
                        begin
                            rx_q <= {rx_q[7:0], sda_s_q};
                            scl_q <= 1'b0;
                        end
                        default:
                            if (bidx_q == 4'd8)
                            begin
                                oe_n_q <= 1'b1;
                                rx_byte_q <= rx_q[8:1];
                                nack_q <= rx_q[0];
                                state_q <= H_IDLE;
                            end
                            else
                            begin
                                oe_n_q <= tx_q[8];
                                tx_q <= {tx_q[7:0], 1'b1};
                                bidx_q <= bidx_q + 4'h1;
                            end
                    endcase
                default:
                    state_q <= H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [31:0] stat_w;

    always_comb
    begin
        stat_w = 32'h0;
        stat_w[STAT_BUSY_BIT] = state_q != H_IDLE;
        stat_w[STAT_NACK_BIT] = nack_q;
        stat_w[STAT_DATA_LSB +: 8] = rx_byte_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            reg_rdata <= 32'h0;
        else if (reg_rd && reg_addr == REG_STAT)
            reg_rdata <= stat_w;
        else
            reg_rdata <= 32'h0;
    end

    assign bus.scl = scl_q;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe_n = oe_n_q;

endmodule

// ### verification/eeprom_i2c_checker.sv
`timescale 1ns/100ps
module eeprom_i2c_checker #(
    parameter int PROG = 2000
)
(
    // link domain
    input wire logic link_clk,
    input wire logic link_srst,
    // bus wires
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    // device status
    input wire logic standby,
    input wire logic prog_busy
);
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (link_srst);

    int cnt_q;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // clock high on both samples, so a skewed data edge is not taken
    sequence stop_s;
        scl && $past(scl) && $rose(sda);
    endsequence
    sequence start_s;
        scl && $past(scl) && $fell(sda);
    endsequence

    always_ff @(posedge link_clk)
    begin
        if (link_srst || !prog_busy)
            cnt_q <= 0;
        else
            cnt_q <= cnt_q + 1;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_dev_open_drain: assert property (dev_sda_o == 1'b0)
        else $error("device drives data high");
    a_drive_holds: assert property ($fell(dev_sda_oe_n) |=> !dev_sda_oe_n [*8])
        else $error("device drive too short");
    a_idle_released: assert property (standby |-> dev_sda_oe_n)
        else $error("device drives in standby");
    a_prog_no_ack: assert property (prog_busy |-> dev_sda_oe_n)
        else $error("device drives in program cycle");
    a_prog_length: assert property ($fell(prog_busy) |-> cnt_q >= PROG - 2 && cnt_q <= PROG + 2)
        else $error("program cycle length wrong");
    a_drive_scl_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("device data changed with clock high");
    a_stop_standby: assert property (stop_s |-> ##[1:12] (standby || prog_busy))
        else $error("no standby after stop");
    a_start_wakes: assert property (start_s and !prog_busy |-> ##[1:12] !standby)
        else $error("start not taken");

    c_prog: cover property ($rose(prog_busy));
    c_dev_drive: cover property ($fell(dev_sda_oe_n));
    c_stop: cover property (stop_s ##[1:12] standby);
endmodule

// ### verification/tb_eeprom_i2c.sv
`timescale 1ns/100ps
module tb_eeprom_i2c;
    import eeprom_i2c_pkg::*;
    localparam int PROG = 2000;
    logic sys_clk, srst, link_clk, link_srst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, st;
    logic reg_wr, reg_rd, wcp, standby, prog_busy;
    logic [2:0] strap;
    logic [7:0] mem_m [256];
    logic [7:0] base, d, prot_m;
    int n_errors, num_checks;

    eeprom_i2c_if bus ();
    eeprom_i2c_host #(.QTR(20)) i_eeprom_i2c_host (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(bus.host));
    eeprom_i2c_dev #(.PROG_CYCLES(PROG)) i_eeprom_i2c_dev (.link_clk(link_clk), .link_srst(link_srst),
        .bus(bus.dev), .addr_strap_bit2(strap[2]), .addr_strap_bit1(strap[1]), .addr_strap_bit0(strap[0]),
        .write_control_pin(wcp), .standby(standby), .prog_busy(prog_busy));
    eeprom_i2c_checker #(.PROG(PROG)) i_eeprom_i2c_checker (.link_clk(link_clk), .link_srst(link_srst),
        .scl(bus.scl), .sda(bus.sda), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n),
        .standby(standby), .prog_busy(prog_busy));

    // ----------------------------------------
    // clocks
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // odd offset keeps the link clock out of phase with the system clock
    initial
    begin
        link_clk = 1'b0;
        link_srst = 1'b1;
        #3;
        fork
            forever #16 link_clk = ~link_clk;
            begin
                repeat (10) @(posedge link_clk);
                link_srst <= 1'b0;
            end
        join
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // one host command, then poll until the host is idle again
    task automatic op(input logic [2:0] o, input logic [7:0] b, input logic ak);
        int i;
        wr(REG_CMD, {16'h0000, b, 4'h0, ak, o});
        for (i = 0; i < 2000; i++)
        begin
            rd(REG_STAT, st);
            if (st[STAT_BUSY_BIT] === 1'b0)
                break;
        end
        if (i == 2000)
        begin
            chk(1'b0, "host hang");
            report_and_stop();
        end
    endtask

    task automatic wb(input logic [7:0] b, input logic nak);
        op(OP_WRITE, b, 1'b1);
        chk(st[STAT_NACK_BIT] === nak, "ack bit");
    endtask

    task automatic rb(input logic [7:0] e, input logic last);
        op(OP_READ, 8'h00, last);
        chk(st[15:8] === e, "read byte");
    endtask

    task automatic wait_prog();
        int i;
        for (i = 0; i < 100 && prog_busy !== 1'b1; i++)
            @(posedge sys_clk);
        chk(prog_busy === 1'b1, "no program cycle");
        if (prog_busy !== 1'b1)
            report_and_stop();
    endtask

    task automatic end_prog();
        int i;
        for (i = 0; i < 10 * PROG && prog_busy !== 1'b0; i++)
            @(posedge sys_clk);
        chk(prog_busy === 1'b0, "program stuck");
        if (prog_busy !== 1'b0)
            report_and_stop();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        srst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        wcp = 1'b0;
        n_errors = 0;
        num_checks = 0;
        void'($urandom(32'hdd76158c));
        strap = 3'($urandom);
        base = 8'($urandom);
        prot_m = PROT_RESET;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (60) @(posedge sys_clk);
        chk(standby === 1'b1 && prog_busy === 1'b0, "reset state");
        rd(8'h08, st);
        chk(st === 32'h0, "unmapped read");
        $display("test reset done");

        op(OP_START, 8'h00, 1'b0);
        wb({MEM_TYPE_ID, strap, 1'b0}, 1'b0);
        wb(base, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            d = 8'($urandom);
            mem_m[{base[7:4], 4'(base[3:0] + i)}] = d;
            wb(d, 1'b0);
        end
        op(OP_STOP, 8'h00, 1'b0);
        wait_prog();
        op(OP_START, 8'h00, 1'b0);
        wb({MEM_TYPE_ID, strap, 1'b1}, 1'b1);
        op(OP_STOP, 8'h00, 1'b0);
        end_prog();
        $display("test page write done");

        op(OP_START, 8'h00, 1'b0);
        wb({MEM_TYPE_ID, strap, 1'b1}, 1'b0);
        rb(mem_m[base], 1'b1);
        op(OP_STOP, 8'h00, 1'b0);
        $display("test current read done");

        for (int j = 0; j < 2; j++)
        begin
            wcp <= 1'(j);
            op(OP_START, 8'h00, 1'b0);
            wb({MEM_TYPE_ID, strap, 1'b0}, 1'b0);
            wb({base[7:4], 4'h0}, 1'b0);
            if (j == 1)
            begin
                wb(~mem_m[{base[7:4], 4'h0}], 1'b0);
                op(OP_STOP, 8'h00, 1'b0);
                repeat (100) @(posedge sys_clk);
                chk(prog_busy === 1'b0, "program with write control high");
                op(OP_START, 8'h00, 1'b0);
                wb({MEM_TYPE_ID, strap, 1'b0}, 1'b0);
                wb({base[7:4], 4'h0}, 1'b0);
            end
            op(OP_START, 8'h00, 1'b0);
            wb({MEM_TYPE_ID, strap, 1'b1}, 1'b0);
            for (int i = 0; i < 16; i++)
                rb(mem_m[{base[7:4], 4'(i)}], 1'(i == 15));
            op(OP_STOP, 8'h00, 1'b0);
        end
        wcp <= 1'b0;
        $display("test sequential read done");

        for (int k = 1; k < 8; k = k * 2)
        begin
            op(OP_START, 8'h00, 1'b0);
            wb({MEM_TYPE_ID, strap ^ 3'(k), 1'b1}, 1'b1);
            op(OP_STOP, 8'h00, 1'b0);
        end
        $display("test strap mismatch done");

        for (int j = 0; j < 2; j++)
        begin
            op(OP_START, 8'h00, 1'b0);
            wb({PROT_TYPE_ID, strap, 1'b1}, 1'b0);
            rb(prot_m, 1'b1);
            op(OP_STOP, 8'h00, 1'b0);
            if (j == 0)
            begin
                prot_m = 8'($urandom);
                op(OP_START, 8'h00, 1'b0);
                wb({PROT_TYPE_ID, strap, 1'b0}, 1'b0);
                wb(8'h00, 1'b0);
                wb(prot_m, 1'b0);
                op(OP_STOP, 8'h00, 1'b0);
                wait_prog();
                end_prog();
            end
        end
        $display("test protection done");
        report_and_stop();
    end
endmodule
